// [rtl/pcsb_slot_bank.sv]
// ****************************************
// Channel two slot configuration bank
// ****************************************
module pcsb_slot_bank
   import pcsb_pkg::*;
(
   input wire logic mclk_i, // 200 MHz clock
   input wire logic rst_i, // Synchronous reset, high
   input wire logic [5:0] reg_addr_i, // Register address
   input wire logic [15:0] reg_wdata_i, // Write data
   input wire logic reg_we_i, // Write strobe
   input wire logic reg_re_i, // Read strobe
   output logic [15:0] reg_rdata_o, // Read data, one cycle later
   input wire logic [1:0] slot_monitor_mode_i, // Monitoring mode
   input wire logic init_data_capture_en_i, // Init data read enable
   input wire logic sync_mode_en_i, // 1 sync, 0 async
   input wire logic [4:0] slot1_data_len_i, // Slot 1 length code
   input wire logic slot1_check_sel_i, // Slot 1 check select
   input wire logic [4:0] slot2_data_len_i, // Slot 2 length code
   input wire logic slot2_check_sel_i, // Slot 2 check select
   input wire logic frame_valid_i, // Frame received pulse
   input wire logic [2:0] frame_slot_i, // Slot 1..6 of frame
   input wire logic [4:0] frame_ident_i, // Received ident
   input wire logic [11:0] frame_start_i, // Frame start in us
   output logic [29:0] eff_len_o, // Per slot data bits, slot 1 low
   output logic [5:0] eff_check_o, // Per slot 1 parity, 0 CRC
   output logic [29:0] exp_ident_o, // Per slot expected ident
   output logic [71:0] start_time_o, // Per slot earliest start
   output logic [11:0] end_time_o, // End of last slot
   output logic window_en_o, // Slot monitoring active
   output logic prog_phase_o, // 1 while bank writable
   output logic tsm_parity_err_o, // A window register fails parity
   output logic slot_timing_err_o, // Frame outside its window
   output logic ident_err_o // Frame ident mismatch
);
   // ****************************************
   // Register storage
   // ****************************************
   logic [15:0] cfg34_reg, cfg56_reg, id123_reg, id456_reg, end_reg;
   logic [15:0] es_reg [6];
   logic prog_reg;
   logic [15:0] rdata_reg;
   logic [29:0] len_reg;
   logic [5:0] chk_reg;
   logic parity_err_reg, tim_err_reg, id_err_reg, win_reg;
   logic [15:0] rdata_next;

   // Write decode; locked bank drops every configuration write
   wire logic wr_ok = reg_we_i && prog_reg;
   wire logic wr_cfg34 = wr_ok && (reg_addr_i == PCSB_ADDR_CFG34);
   wire logic wr_cfg56 = wr_ok && (reg_addr_i == PCSB_ADDR_CFG56);
   wire logic wr_id123 = wr_ok && (reg_addr_i == PCSB_ADDR_ID123);
   wire logic wr_id456 = wr_ok && (reg_addr_i == PCSB_ADDR_ID456);
   wire logic wr_end = wr_ok && (reg_addr_i == PCSB_ADDR_END);
   wire logic is_es = (reg_addr_i >= PCSB_ADDR_ES1) && (reg_addr_i <= PCSB_ADDR_ES6);
   wire logic [2:0] es_idx = 3'(reg_addr_i - PCSB_ADDR_ES1);
   wire logic end_prog_cmd = reg_we_i && (reg_addr_i == PCSB_ADDR_CMD)
                             && (reg_wdata_i == PCSB_CMD_END_PROG);

   // Configuration registers, reserved bits forced to zero
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cfg34_reg <= PCSB_RST_CFG;
         cfg56_reg <= PCSB_RST_CFG;
         id123_reg <= PCSB_RST_ID123;
         id456_reg <= PCSB_RST_ID456;
         end_reg <= PCSB_RST_END;
      end else begin
         if (wr_cfg34) cfg34_reg <= reg_wdata_i & PCSB_MASK_CFG;
         if (wr_cfg56) cfg56_reg <= reg_wdata_i & PCSB_MASK_CFG;
         if (wr_id123) id123_reg <= reg_wdata_i & PCSB_MASK_ID;
         if (wr_id456) id456_reg <= reg_wdata_i & PCSB_MASK_ID;
         if (wr_end) end_reg <= reg_wdata_i & PCSB_MASK_TSM;
      end
   end

   // Earliest start registers, parity bit stored as written
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         es_reg[0] <= PCSB_RST_ES1;
         es_reg[1] <= PCSB_RST_ES2;
         es_reg[2] <= PCSB_RST_ES3;
         es_reg[3] <= PCSB_RST_ES456;
         es_reg[4] <= PCSB_RST_ES456;
         es_reg[5] <= PCSB_RST_ES456;
      end else if (wr_ok && is_es) begin
         es_reg[es_idx] <= reg_wdata_i & PCSB_MASK_TSM;
      end
   end

   // Lock latch; only reset reopens programming
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prog_reg <= 1'b1;
      end else if (end_prog_cmd) begin
         prog_reg <= 1'b0;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Unmapped and command addresses read zero
   always_comb begin
      rdata_next = 16'h0000;
      if (reg_addr_i == PCSB_ADDR_CFG34) rdata_next = cfg34_reg;
      else if (reg_addr_i == PCSB_ADDR_CFG56) rdata_next = cfg56_reg;
      else if (reg_addr_i == PCSB_ADDR_ID123) rdata_next = id123_reg;
      else if (reg_addr_i == PCSB_ADDR_ID456) rdata_next = id456_reg;
      else if (is_es) rdata_next = es_reg[es_idx];
      else if (reg_addr_i == PCSB_ADDR_END) rdata_next = end_reg;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) rdata_reg <= 16'h0000;
      else if (reg_re_i) rdata_reg <= rdata_next;
   end

   // ****************************************
   // Effective slot settings
   // ****************************************
   // Slot 1 override; programmed values are kept but not applied
   wire logic force_s1 = init_data_capture_en_i || !sync_mode_en_i
                         || (slot_monitor_mode_i == PCSB_MON_SIMPLE);
   wire logic [29:0] raw_code = {cfg56_reg[10:6], cfg56_reg[4:0], cfg34_reg[10:6],
                                 cfg34_reg[4:0], slot2_data_len_i, slot1_data_len_i};
   wire logic [5:0] raw_chk = {cfg56_reg[PCSB_CHK_HI_POS], cfg56_reg[PCSB_CHK_LO_POS],
                               cfg34_reg[PCSB_CHK_HI_POS], cfg34_reg[PCSB_CHK_LO_POS],
                               slot2_check_sel_i, slot1_check_sel_i};
   wire logic [29:0] sel_code = force_s1 ? {6{slot1_data_len_i}} : raw_code;
   wire logic [5:0] sel_chk = force_s1 ? {6{slot1_check_sel_i}} : raw_chk;
   wire logic [29:0] dec_len;

   // One decoder per slot
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_dec
         pcsb_len_dec u_dec (
            .code_i(sel_code[g*5 +: 5]),
            .len_o(dec_len[g*5 +: 5])
         );
      end
   endgenerate

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         len_reg <= {6{PCSB_LEN_DEF}};
         chk_reg <= 6'h00;
      end else begin
         len_reg <= dec_len;
         chk_reg <= sel_chk;
      end
   end

   // ****************************************
   // Monitoring and frame checks
   // ****************************************
   wire logic win_en = (slot_monitor_mode_i == PCSB_MON_STD)
                       || (slot_monitor_mode_i == PCSB_MON_SIMPLE);
   wire logic [29:0] idents = {id456_reg[14:10], id456_reg[9:5], id456_reg[4:0],
                               id123_reg[14:10], id123_reg[9:5], id123_reg[4:0]};
   wire logic [71:0] starts = {es_reg[5][11:0], es_reg[4][11:0], es_reg[3][11:0],
                               es_reg[2][11:0], es_reg[1][11:0], es_reg[0][11:0]};
   // Odd parity means an odd count of ones over all 16 bits
   wire logic parity_bad = !(^es_reg[0]) || !(^es_reg[1]) || !(^es_reg[2])
                        || !(^es_reg[3]) || !(^es_reg[4]) || !(^es_reg[5])
                        || !(^end_reg);
   wire logic slot_ok = (frame_slot_i != 3'h0) && (frame_slot_i <= 3'h6);
   wire logic [2:0] fidx = slot_ok ? 3'(frame_slot_i - 3'h1) : 3'h0;
   wire logic [11:0] f_es = es_reg[fidx][11:0];
   wire logic [4:0] f_id = idents[fidx*5 +: 5];
   // Late check uses the end of the last slot, not a per-slot end
   wire logic tim_bad = frame_valid_i && slot_ok && win_en
                        && ((frame_start_i < f_es) || (frame_start_i > end_reg[11:0]));
   wire logic id_bad = frame_valid_i && slot_ok && (frame_ident_i != f_id);

   // Window enable registered so every output leaves a flip-flop
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         parity_err_reg <= 1'b0;
         tim_err_reg <= 1'b0;
         id_err_reg <= 1'b0;
         win_reg <= 1'b0;
      end else begin
         parity_err_reg <= parity_bad;
         tim_err_reg <= tim_bad;
         id_err_reg <= id_bad;
         win_reg <= win_en && sync_mode_en_i;
      end
   end

   // Outputs that are straight register copies
   assign reg_rdata_o = rdata_reg;
   assign eff_len_o = len_reg;
   assign eff_check_o = chk_reg;
   assign exp_ident_o = idents;
   assign start_time_o = starts;
   assign end_time_o = end_reg[11:0];
   assign window_en_o = win_reg;
   assign prog_phase_o = prog_reg;
   assign tsm_parity_err_o = parity_err_reg;
   assign slot_timing_err_o = tim_err_reg;
   assign ident_err_o = id_err_reg;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence end_prog_seq;
      end_prog_cmd ##1 1'b1;
   endsequence

   prog_lock_a: assert property (end_prog_seq |-> !prog_phase_o)
      else $error("End of programming did not lock bank");
   lock_hold_a: assert property (!prog_reg && reg_we_i
      |=> $stable(cfg34_reg) && $stable(id123_reg) && $stable(end_reg))
      else $error("Locked bank changed");
   len_range_a: assert property (!force_s1 && cfg34_reg[4:0] >= PCSB_LEN_MIN
      && cfg34_reg[4:0] <= PCSB_LEN_MAX |=> eff_len_o[14:10] == $past(cfg34_reg[4:0]))
      else $error("Slot 3 length not taken from code");
   len_def_a: assert property (!force_s1 && (cfg56_reg[4:0] < PCSB_LEN_MIN)
      |=> eff_len_o[24:20] == PCSB_LEN_DEF)
      else $error("Slot 5 default length wrong");
   override_a: assert property (force_s1
      |=> eff_len_o[19:15] == eff_len_o[4:0] && eff_check_o[3] == eff_check_o[0])
      else $error("Slot 1 override not applied");
   chk_sel_a: assert property (!force_s1 |=> eff_check_o[2] == $past(cfg34_reg[5]))
      else $error("Slot 3 check select wrong");
   rsv_read_a: assert property (reg_re_i && reg_addr_i == PCSB_ADDR_CFG56
      |=> reg_rdata_o[15:12] == 4'h0)
      else $error("Reserved bits not zero");
   parity_err_a: assert property (!(^es_reg[2]) |=> tsm_parity_err_o)
      else $error("Parity error missed");
   timing_err_a: assert property (frame_valid_i && slot_ok && !win_en
      |=> !slot_timing_err_o)
      else $error("Timing error while monitoring off");
   ident_err_a: assert property (frame_valid_i && frame_slot_i == 3'h4
      && frame_ident_i != id456_reg[4:0] |=> ident_err_o)
      else $error("Ident mismatch missed");
endmodule : pcsb_slot_bank

// [rtl/pcsb_pkg.sv]
// Functional notes
// - Slot 3/4 length codes 8..28 used directly; other codes give 20 bits.
// - Slot 5/6 length codes decoded the same way, default 20 bits.
// - Slot 3/4 check select bit: 0 means CRC, 1 means parity.
// - Slot 5/6 check select bit likewise; bits 15:12 reserved, read zero.
// - Expected idents for slots 1-3 held at bits 4:0, 9:5, 14:10.
// - Expected idents for slots 4-6 held at the same positions.
// - Each slot keeps a 12-bit earliest start in microseconds after sync edge.
// - A 12-bit end of last slot kept in microseconds after sync edge.
// - Bit 15 of window registers is odd parity, supplied by writer, checked here.
// - Writing 0x1111 to command register locks bank until device reset.
// - Init capture, simple monitoring or async mode force slot 1 frame settings.
// - Windows used only when monitor mode is 01 or 10.
package pcsb_pkg;
   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [5:0] PCSB_ADDR_CMD = 6'h1E;
   localparam logic [5:0] PCSB_ADDR_CFG34 = 6'h21;
   localparam logic [5:0] PCSB_ADDR_CFG56 = 6'h22;
   localparam logic [5:0] PCSB_ADDR_ID123 = 6'h23;
   localparam logic [5:0] PCSB_ADDR_ID456 = 6'h24;
   localparam logic [5:0] PCSB_ADDR_ES1 = 6'h25;
   localparam logic [5:0] PCSB_ADDR_ES6 = 6'h2A;
   localparam logic [5:0] PCSB_ADDR_END = 6'h2B;
   // ****************************************
   // Reset values and field masks
   // ****************************************
   localparam logic [15:0] PCSB_RST_CFG = 16'h0514;
   localparam logic [15:0] PCSB_RST_ID123 = 16'h4E51;
   localparam logic [15:0] PCSB_RST_ID456 = 16'h5AA8;
   localparam logic [15:0] PCSB_RST_ES1 = 16'h002C;
   localparam logic [15:0] PCSB_RST_ES2 = 16'h00B5;
   localparam logic [15:0] PCSB_RST_ES3 = 16'h8149;
   localparam logic [15:0] PCSB_RST_ES456 = 16'h8000;
   localparam logic [15:0] PCSB_RST_END = 16'h81EC;
   localparam logic [15:0] PCSB_MASK_CFG = 16'h0FFF;
   localparam logic [15:0] PCSB_MASK_ID = 16'h7FFF;
   localparam logic [15:0] PCSB_MASK_TSM = 16'h8FFF;
   localparam logic [15:0] PCSB_CMD_END_PROG = 16'h1111;
   // ****************************************
   // Field positions and codes
   // ****************************************
   localparam int PCSB_LEN_LO_POS = 0;
   localparam int PCSB_CHK_LO_POS = 5;
   localparam int PCSB_LEN_HI_POS = 6;
   localparam int PCSB_CHK_HI_POS = 11;
   localparam logic [4:0] PCSB_LEN_MIN = 5'h08;
   localparam logic [4:0] PCSB_LEN_MAX = 5'h1C;
   localparam logic [4:0] PCSB_LEN_DEF = 5'h14;
   localparam logic [1:0] PCSB_MON_STD = 2'h1;
   localparam logic [1:0] PCSB_MON_SIMPLE = 2'h2;
endpackage : pcsb_pkg

// [rtl/pcsb_len_dec.sv]
// ****************************************
// Data length decoder for one slot
// ****************************************
module pcsb_len_dec
   import pcsb_pkg::*;
(
   input wire logic [4:0] code_i, // Programmed length code
   output logic [4:0] len_o // Data bits in the frame
);
   wire logic code_ok;
   // Out-of-range codes fall back so a bad write never yields a zero length
   assign code_ok = (code_i >= PCSB_LEN_MIN) && (code_i <= PCSB_LEN_MAX);
   assign len_o = code_ok ? code_i : PCSB_LEN_DEF;
endmodule : pcsb_len_dec

// [test/pcsb_host.sv]
// ****************************************
// Host side register master
// ****************************************
module pcsb_host
   import pcsb_pkg::*;
(
   input wire logic mclk_i, // Bank clock
   output logic [5:0] reg_addr_o, // Register address
   output logic [15:0] reg_wdata_o, // Write data
   output logic reg_we_o, // Write strobe
   output logic reg_re_o, // Read strobe
   input wire logic [15:0] reg_rdata_i // Read data
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      reg_addr_o = 6'h00;
      reg_wdata_o = 16'h0000;
      reg_we_o = 1'b0;
      reg_re_o = 1'b0;
   end
   // One-cycle strobe; data inverted after so a stale word never lingers
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_we_o = 1'b1;
      @(negedge mclk_i);
      reg_we_o = 1'b0;
      reg_wdata_o = ~d;
   endtask : wr
   // Read data taken one cycle after the strobe edge
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_re_o = 1'b1;
      @(negedge mclk_i);
      reg_re_o = 1'b0;
      d = reg_rdata_i;
   endtask : rd
endmodule : pcsb_host

// [test/pcsb_slot_bank_tb.sv]
// ****************************************
// Slot bank bench against integer model
// ****************************************
module pcsb_slot_bank_tb
   import pcsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i, rst_i, we, re, init, sync, c1, c2, fv, wen, prog, perr, terr, ierr, m_prog;
   logic [1:0] mode;
   logic [2:0] fs;
   logic [4:0] l1, l2, fid;
   logic [5:0] addr, ec;
   logic [11:0] fst, et;
   logic [15:0] wd, rdat;
   logic [29:0] el, ei;
   logic [71:0] st;
   logic [31:0] lf = 32'h58B0;
   logic [31:0] r;
   int n_fail, checked, mreg [30:43];
   pcsb_slot_bank dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat), .slot_monitor_mode_i(mode),
      .init_data_capture_en_i(init), .sync_mode_en_i(sync), .slot1_data_len_i(l1),
      .slot1_check_sel_i(c1), .slot2_data_len_i(l2), .slot2_check_sel_i(c2),
      .frame_valid_i(fv), .frame_slot_i(fs), .frame_ident_i(fid), .frame_start_i(fst),
      .eff_len_o(el), .eff_check_o(ec), .exp_ident_o(ei), .start_time_o(st),
      .end_time_o(et), .window_en_o(wen), .prog_phase_o(prog), .tsm_parity_err_o(perr),
      .slot_timing_err_o(terr), .ident_err_o(ierr));
   pcsb_host host (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wdata_o(wd), .reg_we_o(we),
      .reg_re_o(re), .reg_rdata_i(rdat));
   // 200 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction : rnd
   function automatic int dec(int c);
      return (c >= 8 && c <= 28) ? c : 20;
   endfunction : dec
   // Reserved bits cleared first so the stored word keeps the parity
   function automatic logic [15:0] wpar(logic [15:0] d);
      d[14:12] = 3'h0;
      d[15] = ~^d[14:0];
      return d;
   endfunction : wpar
   task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   // Model follows device reset; lock lifts only here
   task automatic do_reset();
      mreg = '{0, 0, 0, 16'h0514, 16'h0514, 16'h4E51, 16'h5AA8, 16'h002C, 16'h00B5,
         16'h8149, 16'h8000, 16'h8000, 16'h8000, 16'h81EC};
      rst_i = 1'b1;
      repeat (20) @(negedge mclk_i);
      rst_i = 1'b0;
      m_prog = 1'b1;
   endtask : do_reset
   // Reserved bits drop; nothing sticks once locked
   task automatic wreg(input int a, input logic [15:0] d);
      host.wr(6'(a), d);
      if (m_prog && a > 32) mreg[a] = d & (a < 35 ? 16'h0FFF : a < 37 ? 16'h7FFF : 16'h8FFF);
      if (a == 30 && d == 16'h1111) m_prog = 1'b0;
   endtask : wreg
   task automatic rd_all();
      logic [15:0] d;
      for (int a = 33; a < 44; a++) begin
         host.rd(6'(a), d);
         chk("readback", 72'(mreg[a]), 72'(d));
      end
      host.rd(6'h3F, d);
      chk("unmapped", 72'(0), 72'(d));
   endtask : rd_all
   task automatic check_all();
      logic [29:0] x_len, x_id;
      logic [5:0] x_chk;
      logic [71:0] x_st;
      logic [15:0] cw;
      logic ov, pe;
      repeat (2) @(negedge mclk_i);
      ov = init || mode == 2'h2 || !sync;
      pe = 1'b0;
      for (int s = 0; s < 6; s++) begin
         cw = (s < 2) ? {10'h0, s ? c2 : c1, s ? l2 : l1} : 16'(mreg[32 + s / 2] >> (6 * (s % 2)));
         if (ov) cw = {10'h0, c1, l1};
         x_len[5 * s +: 5] = 5'(dec(cw[4:0]));
         x_chk[s] = cw[5];
         x_id[5 * s +: 5] = 5'(mreg[35 + s / 3] >> (5 * (s % 3)));
         x_st[12 * s +: 12] = 12'(mreg[37 + s]);
      end
      for (int a = 37; a < 44; a++) pe |= ~^16'(mreg[a]);
      chk("eff_len", 72'(x_len), 72'(el));
      chk("eff_check", 72'(x_chk), 72'(ec));
      chk("exp_ident", 72'(x_id), 72'(ei));
      chk("start_time", x_st, st);
      chk("end_time", 72'(12'(mreg[43])), 72'(et));
      chk("window_en", 72'((mode == 2'h1 || mode == 2'h2) && sync), 72'(wen));
      chk("parity_err", 72'(pe), 72'(perr));
      chk("prog_phase", 72'(m_prog), 72'(prog));
   endtask : check_all
   // Slot, ident and start all from one random word; slots 0 and 7 ignored
   task automatic frame(input logic [31:0] q);
      int i;
      logic v, ie, te;
      logic [4:0] xid;
      v = q[2:0] >= 1 && q[2:0] <= 6;
      i = v ? q[2:0] - 1 : 0;
      xid = 5'(mreg[35 + i / 3] >> (5 * (i % 3)));
      @(negedge mclk_i);
      fv = 1'b1;
      fs = q[2:0];
      fid = q[3] ? xid : q[8:4];
      fst = q[31:20];
      ie = v && fid !== xid;
      te = v && mode inside {2'h1, 2'h2} && (fst < 12'(mreg[37 + i]) || fst > 12'(mreg[43]));
      @(negedge mclk_i);
      fv = 1'b0;
      chk("ident_err", 72'(ie), 72'(ierr));
      chk("timing_err", 72'(te), 72'(terr));
      @(negedge mclk_i);
      chk("err_pulse", 72'(0), 72'({ierr, terr}));
   endtask : frame
   // Hang guard
   initial begin
      #400us;
      n_fail++;
      end_sim();
   end
   // Main sequence
   initial begin
      {init, c1, c2, fv, fs, fid, fst, l1, l2} = '0;
      mode = 2'h1;
      sync = 1'b1;
      do_reset();
      rd_all();
      check_all();
      $display("test reset done");
      for (int c = 0; c < 32; c++) begin
         r = rnd();
         wreg(33, {r[15:12], r[0], 5'(c), r[1], 5'(31 - c)});
         wreg(34, {r[15:12], r[2], r[20:16], r[3], 5'(c)});
         {l1, c1, l2, c2} = r[31:20];
         check_all();
      end
      rd_all();
      $display("test length decode done");
      for (int k = 0; k < 4; k++) begin
         init = k == 1;
         mode = k == 2 ? 2'h2 : 2'h1;
         sync = k != 3;
         check_all();
      end
      $display("test override done");
      for (int a = 35; a < 44; a++) wreg(a, a < 37 ? 16'(rnd()) : wpar(16'(rnd())));
      check_all();
      for (int k = 0; k < 48; k++) begin
         mode = 2'(k);
         sync = k[2];
         frame(rnd());
         check_all();
      end
      wreg(39, wpar(16'(rnd())) ^ 16'h8000);
      check_all();
      $display("test frames done");
      wreg(30, 16'h1111);
      wreg(33, 16'h0FFF);
      check_all();
      rd_all();
      do_reset();
      check_all();
      $display("test lock done");
      end_sim();
   end
endmodule : pcsb_slot_bank_tb
